// File: rtl/bsc_pkg.sv
package bsc_pkg;

	// Register bus offsets
	localparam logic [3:0] BSC_OFS_FLASH_CTL   = 4'h0;
	localparam logic [3:0] BSC_OFS_AUX_CTL     = 4'h1;
	localparam logic [3:0] BSC_OFS_STATUS      = 4'h2;
	localparam logic [3:0] BSC_OFS_PC_LO       = 4'h3;
	localparam logic [3:0] BSC_OFS_PC_HI       = 4'h4;
	localparam logic [3:0] BSC_OFS_BOOT_VEC    = 4'h5;
	localparam logic [3:0] BSC_OFS_SPARE       = 4'h6;
	localparam logic [3:0] BSC_OFS_BOOT_STAT   = 4'h7;
	localparam logic [3:0] BSC_OFS_SECURITY    = 4'h8;
	localparam logic [3:0] BSC_OFS_LOADER_HI   = 4'h9;

	// Field positions
	localparam int unsigned BSC_FC_BUSY_BIT    = 0;
	localparam int unsigned BSC_FC_MODE_LSB    = 1;
	localparam int unsigned BSC_FC_MAP_SEL_BIT = 3;
	localparam int unsigned BSC_AUX_BOOT_EN    = 0;
	localparam int unsigned BSC_SEC_X2_BIT     = 7;
	localparam int unsigned BSC_SEC_JUMP_BIT   = 6;
	localparam int unsigned BSC_ST_HW_BIT      = 0;
	localparam int unsigned BSC_ST_DONE_BIT    = 1;
	localparam int unsigned BSC_ST_JUMP_BIT    = 2;
	localparam int unsigned BSC_ST_INT_BIT     = 3;

	// Values loaded at boot
	localparam logic [7:0]  BSC_FLASH_CTL_HW   = 8'h00;
	localparam logic [7:0]  BSC_FLASH_CTL_SW   = 8'hF0;
	localparam logic [15:0] BSC_PC_BOOT        = 16'hF800;
	localparam logic [15:0] BSC_PC_USER        = 16'h0000;
	localparam logic [7:0]  BSC_LOADER_LOW     = 8'h00;

	// Nonvolatile defaults as shipped
	localparam logic        BSC_JUMP_DEF       = 1'b0;
	localparam logic        BSC_X2_DEF         = 1'b1;
	localparam logic [7:0]  BSC_BOOT_VEC_DEF   = 8'hFC;
	localparam logic [7:0]  BSC_SPARE_DEF      = 8'hFF;
	localparam logic [7:0]  BSC_BOOT_STAT_DEF  = 8'hFF;

	// Code-space ranges
	localparam logic [15:0] BSC_USER_TOP       = 16'h7FFF;
	localparam logic [15:0] BSC_BOOT_BASE      = 16'hF800;
	localparam logic [15:0] BSC_EXTRA_ROW_MASK = 16'h007F;

	typedef enum logic [1:0] {
		BS_WAIT = 2'b01,
		BS_RUN  = 2'b10
	} bsc_boot_st_t;

	typedef enum logic [5:0] {
		TG_NONE      = 6'h01,
		TG_USER      = 6'h02,
		TG_BOOT      = 6'h04,
		TG_EXTRA_ROW = 6'h08,
		TG_HW_BYTE   = 6'h10,
		TG_EXT_CODE  = 6'h20
	} bsc_tgt_t;

endpackage

// File: rtl/bsc_code_decode.sv
`timescale 1ns/10ps
module bsc_code_decode (
	// Flash configuration
	input  wire logic          [1:0]  mode_i,
	input  wire logic                 map_select_i,
	input  wire logic                 boot_space_enable_i,
	// Code fetch context
	input  wire logic                 from_boot_i,
	input  wire logic                 external_i,
	input  wire logic          [15:0] ptr_i,
	// Result
	output bsc_pkg::bsc_tgt_t         tgt_o,
	output logic               [15:0] addr_o
);
	import bsc_pkg::*;

	logic in_user;
	logic in_boot;

	always_comb begin
		in_user = (ptr_i <= BSC_USER_TOP);
		in_boot = (ptr_i >= BSC_BOOT_BASE);
		tgt_o   = TG_NONE;
		addr_o  = ptr_i;
		if (external_i) begin
			if (!mode_i[0]) begin
				tgt_o = TG_EXT_CODE;
			end
		end else if (from_boot_i && !boot_space_enable_i) begin
			tgt_o = TG_NONE;
		end else begin
			case (mode_i)
				2'b00: begin
					if (in_user) begin
						tgt_o = TG_USER;
					end else if (from_boot_i && !map_select_i && in_boot) begin
						tgt_o = TG_BOOT;
					end else if (from_boot_i && map_select_i) begin
						tgt_o  = TG_USER;
						addr_o = ptr_i & BSC_USER_TOP;
					end
				end
				2'b01: begin
					tgt_o  = TG_EXTRA_ROW;
					addr_o = ptr_i & BSC_EXTRA_ROW_MASK;
				end
				2'b10: begin
					tgt_o = TG_HW_BYTE;
				end
				2'b11: begin
					if (in_user) begin
						tgt_o = TG_USER;
					end
				end
				default: begin
					tgt_o = TG_NONE;
				end
			endcase
		end
	end

endmodule

// File: rtl/bsc_nv_bytes.sv
`timescale 1ns/10ps
module bsc_nv_bytes (
	// Clock and power-on reset
	input  wire logic        mclk_i,
	input  wire logic        por_i,
	// Update port
	input  wire logic        wr_i,
	input  wire logic [3:0]  waddr_i,
	input  wire logic [7:0]  wdata_i,
	// Stored values
	output logic             boot_jump_bit_o,
	output logic             x2_bit_o,
	output logic      [7:0]  boot_vector_byte_o,
	output logic      [7:0]  spare_byte_o,
	output logic      [7:0]  boot_status_byte_o
);
	import bsc_pkg::*;

	typedef struct packed {
		logic       jump;
		logic       x2;
		logic [7:0] vec;
		logic [7:0] spare;
		logic [7:0] stat;
	} bsc_nv_state_t;

	// Survives the main reset; only power-on restores shipped values
	localparam bsc_nv_state_t BSC_NV_RST = '{
		jump:  BSC_JUMP_DEF,
		x2:    BSC_X2_DEF,
		vec:   BSC_BOOT_VEC_DEF,
		spare: BSC_SPARE_DEF,
		stat:  BSC_BOOT_STAT_DEF
	};

	bsc_nv_state_t s_q;
	bsc_nv_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (wr_i) begin
			case (waddr_i)
				BSC_OFS_BOOT_VEC:  s_d.vec   = wdata_i;
				BSC_OFS_SPARE:     s_d.spare = wdata_i;
				BSC_OFS_BOOT_STAT: s_d.stat  = wdata_i;
				BSC_OFS_SECURITY: begin
					s_d.x2   = wdata_i[BSC_SEC_X2_BIT];
					s_d.jump = wdata_i[BSC_SEC_JUMP_BIT];
				end
				default: s_d = s_q;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge por_i) begin
		if (por_i) begin
			s_q <= BSC_NV_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign boot_jump_bit_o    = s_q.jump;
	assign x2_bit_o           = s_q.x2;
	assign boot_vector_byte_o = s_q.vec;
	assign spare_byte_o       = s_q.spare;
	assign boot_status_byte_o = s_q.stat;

endmodule

// File: rtl/bsc_boot_map.sv
// What this block does
// - At reset release the boot-space enable flag is loaded from the boot jump bit.
// - A hardware boot condition at release loads flash control 00h and start address F800h.
// - The hardware boot condition is store-enable low, external access high, latch enable high.
// - With the hardware boot condition the boot loader runs whatever the jump bit says.
// - Without the hardware boot condition flash control becomes F0h and the jump bit decides.
// - Jump bit 1 starts user code at 0000h, jump bit 0 starts the loader at F800h.
// - The strap pins are sampled once at reset release and may change freely afterwards.
// - Extra-row reads decode only the low 7 pointer bits so higher pointers alias down.
// - The boot vector byte is the high byte of the user loader address, low byte 00h.
// - The boot vector byte defaults to FCh, meaning no user loader.
// - As shipped the jump bit is 0 so the boot loader runs after every reset.
`timescale 1ns/10ps
module bsc_boot_map (
	// Clock and resets
	input  wire logic                 mclk_i,
	input  wire logic                 rst_i,
	input  wire logic                 por_i,
	// Strap pins
	input  wire logic                 prog_store_en_n_i,
	output logic                      prog_store_en_n_o,
	output logic                      prog_store_en_oe_o,
	input  wire logic                 core_store_en_n_i,
	input  wire logic                 external_access_n_i,
	input  wire logic                 addr_latch_en_i,
	// Boot results
	output logic               [15:0] start_pc_o,
	output logic                      start_valid_o,
	output logic               [7:0]  flash_control_o,
	output logic                      boot_space_enable_o,
	output logic               [15:0] user_loader_addr_o,
	// Code-space read
	input  wire logic                 code_rd_i,
	input  wire logic          [15:0] code_ptr_i,
	input  wire logic                 code_from_boot_i,
	input  wire logic                 code_rollover_i,
	output logic                      code_valid_o,
	output bsc_pkg::bsc_tgt_t         code_target_o,
	output logic               [15:0] code_addr_o,
	output logic               [7:0]  code_hw_byte_o,
	// Register bus
	input  wire logic          [3:0]  reg_addr_i,
	input  wire logic          [7:0]  reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic               [7:0]  reg_rdata_o
);
	import bsc_pkg::*;

	typedef struct packed {
		bsc_boot_st_t st;
		logic [7:0]   flash_ctl;
		logic         boot_en;
		logic         hw_boot;
		logic         int_code;
		logic [15:0]  start_pc;
		logic         start_vld;
		logic [7:0]   rdata;
		logic         code_vld;
		bsc_tgt_t     code_tgt;
		logic [15:0]  code_addr;
		logic [7:0]   hw_byte;
	} bsc_top_state_t;

	localparam bsc_top_state_t BSC_TOP_RST = '{
		st:        BS_WAIT,
		flash_ctl: BSC_FLASH_CTL_SW,
		boot_en:   1'b0,
		hw_boot:   1'b0,
		int_code:  1'b1,
		start_pc:  BSC_PC_USER,
		start_vld: 1'b0,
		rdata:     8'h00,
		code_vld:  1'b0,
		code_tgt:  TG_NONE,
		code_addr: 16'h0000,
		hw_byte:   8'h00
	};

	bsc_top_state_t s_q;
	bsc_top_state_t s_d;

	logic        jump_bit;
	logic        x2_bit;
	logic [7:0]  boot_vec;
	logic [7:0]  spare;
	logic [7:0]  boot_stat;
	logic        hw_cond;
	logic        code_external;
	bsc_tgt_t    dec_tgt;
	logic [15:0] dec_addr;
	logic [7:0]  security_byte;
	logic [7:0]  status_byte;
	logic [15:0] loader_addr;

	bsc_nv_bytes u_nv (
		.mclk_i             (mclk_i),
		.por_i              (por_i),
		.wr_i               (reg_wr_i),
		.waddr_i            (reg_addr_i),
		.wdata_i            (reg_wdata_i),
		.boot_jump_bit_o    (jump_bit),
		.x2_bit_o           (x2_bit),
		.boot_vector_byte_o (boot_vec),
		.spare_byte_o       (spare),
		.boot_status_byte_o (boot_stat)
	);

	// Pins are tested live only in the sampling cycle
	assign hw_cond = !prog_store_en_n_i && external_access_n_i && addr_latch_en_i;

	assign code_external = !s_q.int_code || code_rollover_i;

	bsc_code_decode u_dec (
		.mode_i              (s_q.flash_ctl[BSC_FC_MODE_LSB +: 2]),
		.map_select_i        (s_q.flash_ctl[BSC_FC_MAP_SEL_BIT]),
		.boot_space_enable_i (s_q.boot_en),
		.from_boot_i         (code_from_boot_i),
		.external_i          (code_external),
		.ptr_i               (code_ptr_i),
		.tgt_o               (dec_tgt),
		.addr_o              (dec_addr)
	);

	assign loader_addr   = {boot_vec, BSC_LOADER_LOW};
	assign security_byte = {x2_bit, jump_bit, 6'h00};
	assign status_byte   = {4'h0, !s_q.int_code, jump_bit, (s_q.st == BS_RUN), s_q.hw_boot};

	always_comb begin
		s_d           = s_q;
		s_d.start_vld = 1'b0;
		s_d.rdata     = 8'h00;
		s_d.code_vld  = 1'b0;
		case (s_q.st)
			BS_WAIT: begin
				// First edge after release: straps and jump bit taken once
				s_d.st        = BS_RUN;
				s_d.boot_en   = jump_bit;
				s_d.hw_boot   = hw_cond;
				s_d.int_code  = external_access_n_i;
				s_d.start_vld = 1'b1;
				if (hw_cond) begin
					s_d.flash_ctl = BSC_FLASH_CTL_HW;
					s_d.start_pc  = BSC_PC_BOOT;
				end else begin
					s_d.flash_ctl = BSC_FLASH_CTL_SW;
					s_d.start_pc  = jump_bit ? BSC_PC_USER : BSC_PC_BOOT;
				end
			end
			BS_RUN: begin
				if (reg_wr_i) begin
					case (reg_addr_i)
						BSC_OFS_FLASH_CTL: begin
							s_d.flash_ctl = {reg_wdata_i[7:1], 1'b0};
						end
						BSC_OFS_AUX_CTL: begin
							s_d.boot_en = reg_wdata_i[BSC_AUX_BOOT_EN];
						end
						default: s_d.boot_en = s_q.boot_en;
					endcase
				end
				if (reg_rd_i) begin
					case (reg_addr_i)
						BSC_OFS_FLASH_CTL: s_d.rdata = s_q.flash_ctl;
						BSC_OFS_AUX_CTL:   s_d.rdata = {7'h00, s_q.boot_en};
						BSC_OFS_STATUS:    s_d.rdata = status_byte;
						BSC_OFS_PC_LO:     s_d.rdata = s_q.start_pc[7:0];
						BSC_OFS_PC_HI:     s_d.rdata = s_q.start_pc[15:8];
						BSC_OFS_BOOT_VEC:  s_d.rdata = boot_vec;
						BSC_OFS_SPARE:     s_d.rdata = spare;
						BSC_OFS_BOOT_STAT: s_d.rdata = boot_stat;
						BSC_OFS_SECURITY:  s_d.rdata = security_byte;
						BSC_OFS_LOADER_HI: s_d.rdata = loader_addr[15:8];
						default:           s_d.rdata = 8'h00;
					endcase
				end
				if (code_rd_i) begin
					s_d.code_vld  = 1'b1;
					s_d.code_tgt  = dec_tgt;
					s_d.code_addr = dec_addr;
					s_d.hw_byte   = (dec_tgt == TG_HW_BYTE) ? security_byte : 8'h00;
				end
			end
			default: begin
				s_d = BSC_TOP_RST;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= BSC_TOP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Store-enable is an input until the straps are taken, then it is driven
	assign prog_store_en_oe_o  = (s_q.st == BS_RUN);
	assign prog_store_en_n_o   = (s_q.st == BS_RUN) ? core_store_en_n_i : 1'b1;
	assign start_pc_o          = s_q.start_pc;
	assign start_valid_o       = s_q.start_vld;
	assign flash_control_o     = s_q.flash_ctl;
	assign boot_space_enable_o = s_q.boot_en;
	assign user_loader_addr_o  = loader_addr;
	assign code_valid_o        = s_q.code_vld;
	assign code_target_o       = s_q.code_tgt;
	assign code_addr_o         = s_q.code_addr;
	assign code_hw_byte_o      = s_q.hw_byte;
	assign reg_rdata_o         = s_q.rdata;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	AST_BOOT_EN_LOAD: assert property (
		(s_q.st == BS_WAIT) |=> (boot_space_enable_o == $past(jump_bit))
	) else $error("boot enable not loaded from jump bit");

	AST_HW_BOOT_LOAD: assert property (
		(s_q.st == BS_WAIT) && hw_cond |=>
			(flash_control_o == 8'h00) && (start_pc_o == 16'hF800) && start_valid_o
	) else $error("hardware boot did not load control and start address");

	AST_HW_COND_SAMPLE: assert property (
		$rose(start_valid_o) |-> s_q.hw_boot == $past(!prog_store_en_n_i
			&& external_access_n_i && addr_latch_en_i)
	) else $error("hardware boot condition captured wrongly");

	AST_HW_FORCES_LOADER: assert property (
		(s_q.st == BS_RUN) && s_q.hw_boot |-> (start_pc_o == 16'hF800)
	) else $error("hardware boot did not force the loader");

	AST_SW_CONTROL: assert property (
		(s_q.st == BS_WAIT) && !hw_cond |=> (flash_control_o == 8'hF0)
	) else $error("flash control not F0h without hardware boot");

	AST_JUMP_START: assert property (
		(s_q.st == BS_WAIT) && !hw_cond |=>
			(start_pc_o == ($past(jump_bit) ? 16'h0000 : 16'hF800))
	) else $error("start address does not follow jump bit");

	AST_SAMPLE_ONCE: assert property (
		(s_q.st == BS_RUN) |=> $stable(start_pc_o) && !start_valid_o
	) else $error("straps taken more than once");

	AST_PIN_DRIVE: assert property (
		$rose(start_valid_o) |-> prog_store_en_oe_o ##1 prog_store_en_oe_o
	) else $error("store-enable not driven after sampling");

	AST_EXTRA_ROW_ALIAS: assert property (
		code_rd_i && (s_q.st == BS_RUN) && (dec_tgt == TG_EXTRA_ROW) |=>
			code_valid_o && (code_addr_o == ($past(code_ptr_i) & 16'h007F))
	) else $error("extra-row pointer not aliased to low 7 bits");

	AST_USER_RANGE: assert property (
		code_valid_o && (code_target_o == TG_USER) |-> (code_addr_o[15] == 1'b0)
	) else $error("user flash read outside 0000h to 7FFFh");

	AST_BOOT_DISABLED: assert property (
		code_rd_i && (s_q.st == BS_RUN) && !code_external && code_from_boot_i
			&& !boot_space_enable_o |=> code_valid_o && (code_target_o == TG_NONE)
	) else $error("flash space reachable with boot enable clear");

	AST_EXT_ONLY: assert property (
		code_rd_i && (s_q.st == BS_RUN) && code_external && !flash_control_o[1] |=>
			code_valid_o && (code_target_o == TG_EXT_CODE)
	) else $error("external code read not routed to external code");

	AST_READ_ONE_CYCLE: assert property (
		!$past(reg_rd_i) |-> (reg_rdata_o == 8'h00)
	) else $error("read data outside its cycle");

	// Pin hand-over, one-time sampling and user loader address
	AST_PIN_RELEASED: assert property (
		(s_q.st == BS_WAIT) |-> !prog_store_en_oe_o && prog_store_en_n_o
	) else $error("store-enable driven before the straps were taken");

	AST_START_ONCE: assert property (
		start_valid_o |-> $past(s_q.st == BS_WAIT)
	) else $error("start pulse outside the sampling cycle");

	AST_EXT_LATCHED: assert property (
		$rose(start_valid_o) |-> (s_q.int_code == $past(external_access_n_i))
	) else $error("external-access level not latched at release");

	AST_LOADER_LOW: assert property (
		reg_rd_i && (s_q.st == BS_RUN) && (reg_addr_i == BSC_OFS_LOADER_HI) |=>
			(reg_rdata_o == $past(boot_vec)) && (user_loader_addr_o[7:0] == 8'h00)
	) else $error("user loader address not vector byte then 00h");

	// Code-space decode
	AST_HW_BYTE_ANY_PTR: assert property (
		code_rd_i && (s_q.st == BS_RUN) && !code_external && !code_from_boot_i
			&& (flash_control_o[2:1] == 2'b10) |=>
			code_valid_o && (code_target_o == TG_HW_BYTE)
	) else $error("mode 10 read did not return the hardware byte");

	AST_USER_LOW: assert property (
		code_rd_i && (s_q.st == BS_RUN) && !code_external && !code_from_boot_i
			&& (flash_control_o[2] == flash_control_o[1]) && !code_ptr_i[15] |=>
			code_valid_o && (code_target_o == TG_USER) && (code_addr_o == $past(code_ptr_i))
	) else $error("low pointer in mode 00 or 11 did not read user flash");

	AST_BOOT_READ: assert property (
		code_rd_i && (s_q.st == BS_RUN) && !code_external && code_from_boot_i
			&& boot_space_enable_o && (flash_control_o[3:1] == 3'b000)
			&& (code_ptr_i >= 16'hF800) |=> code_valid_o && (code_target_o == TG_BOOT)
	) else $error("boot flash not read from boot space");

	AST_CODE_VALID_PULSE: assert property (
		code_valid_o |-> $past(code_rd_i)
	) else $error("code result without a request");

	AST_CODE_HOLD: assert property (
		!code_valid_o |-> $stable(code_target_o) && $stable(code_addr_o)
	) else $error("code result changed without a request");

	// Register bus
	AST_FLASH_CTL_WRITE: assert property (
		reg_wr_i && (s_q.st == BS_RUN) && (reg_addr_i == BSC_OFS_FLASH_CTL) |=>
			(flash_control_o == {$past(reg_wdata_i[7:1]), 1'b0})
	) else $error("flash control write did not land");

	AST_BOOT_EN_WRITE: assert property (
		reg_wr_i && (s_q.st == BS_RUN) && (reg_addr_i == BSC_OFS_AUX_CTL) |=>
			(boot_space_enable_o == $past(reg_wdata_i[BSC_AUX_BOOT_EN]))
	) else $error("boot enable write did not land");

	COV_HW_BOOT: cover property (
		$rose(start_valid_o) && s_q.hw_boot
	);

	COV_USER_START: cover property (
		$rose(start_valid_o) && (start_pc_o == 16'h0000)
	);

	COV_BOOT_READ: cover property (
		code_valid_o && (code_target_o == TG_BOOT)
	);

	COV_EXTRA_ALIAS: cover property (
		code_rd_i && (dec_tgt == TG_EXTRA_ROW) && (code_ptr_i > 16'h007F)
	);

endmodule

// File: testbench/bsc_strap_model.sv
`timescale 1ns/10ps
module bsc_strap_model (
	// Clock and reset source
	input  wire logic mclk_i,
	input  wire logic rst_i,
	// Board strap settings
	input  wire logic store_en_n_set_i,
	input  wire logic ext_access_n_set_i,
	input  wire logic latch_en_set_i,
	input  wire logic latch_float_i,
	// Device side of the store-enable pin
	input  wire logic dev_store_en_n_i,
	input  wire logic dev_store_en_oe_i,
	// Pin levels seen by the device
	output logic      store_en_n_pin_o,
	output logic      ext_access_n_o,
	output logic      latch_en_o
);
	logic [1:0] held_q;
	logic       last_q;
	logic       strap_drive;

	// Straps stay driven through the sampling edge, then the store-enable strap lets go
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			held_q <= 2'h0;
		end else if (held_q != 2'h2) begin
			held_q <= held_q + 2'h1;
		end
	end
	assign strap_drive = (held_q != 2'h2);
	always_ff @(posedge mclk_i) begin
		last_q <= store_en_n_pin_o;
	end
	// Nobody driving: show the inverse of the last level rather than a fixed one
	assign store_en_n_pin_o = dev_store_en_oe_i ? dev_store_en_n_i :
		strap_drive ? store_en_n_set_i : ~last_q;
	assign ext_access_n_o   = ext_access_n_set_i;
	// An open latch-enable strap floats high
	assign latch_en_o       = latch_float_i ? 1'b1 : latch_en_set_i;
endmodule

// File: testbench/bsc_boot_map_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module bsc_boot_map_test;
	import bsc_pkg::*;
	logic mclk_i, rst_i, por_i, store_set, ext_set, ale_set, ale_flt, core_store;
	logic store_pin, ext_pin, ale_pin, pin_o, pin_oe, start_valid, code_valid;
	logic code_rd_i, code_from_boot_i, code_rollover_i, reg_wr_i, reg_rd_i, boot_en;
	logic [15:0] code_ptr_i, start_pc, code_addr, loader_addr;
	logic [3:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i, reg_rdata, flash_ctl, hw_byte;
	bsc_tgt_t    code_tgt;
	int          miscompares, n_checks, cyc;

	bsc_strap_model straps (.mclk_i(mclk_i), .rst_i(rst_i), .store_en_n_set_i(store_set),
		.ext_access_n_set_i(ext_set), .latch_en_set_i(ale_set), .latch_float_i(ale_flt),
		.dev_store_en_n_i(pin_o), .dev_store_en_oe_i(pin_oe), .store_en_n_pin_o(store_pin),
		.ext_access_n_o(ext_pin), .latch_en_o(ale_pin));
	bsc_boot_map dut (.mclk_i(mclk_i), .rst_i(rst_i), .por_i(por_i),
		.prog_store_en_n_i(store_pin), .prog_store_en_n_o(pin_o), .prog_store_en_oe_o(pin_oe),
		.core_store_en_n_i(core_store), .external_access_n_i(ext_pin), .addr_latch_en_i(ale_pin),
		.start_pc_o(start_pc), .start_valid_o(start_valid), .flash_control_o(flash_ctl),
		.boot_space_enable_o(boot_en), .user_loader_addr_o(loader_addr),
		.code_rd_i(code_rd_i), .code_ptr_i(code_ptr_i), .code_from_boot_i(code_from_boot_i),
		.code_rollover_i(code_rollover_i), .code_valid_o(code_valid), .code_target_o(code_tgt),
		.code_addr_o(code_addr), .code_hw_byte_o(hw_byte), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata));

	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	task close_out;
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			close_out();
		end
	end

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i    <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i   <= 1'b0;
		#1;
		`CHK(reg_rdata, exp)
	endtask

	// Reset with given straps, then check the choice made at the first edge after release
	task boot(input logic [3:0] strap, input logic [15:0] pc, input logic [7:0] fc,
		input logic en);
		@(posedge mclk_i);
		rst_i    <= 1'b1;
		store_set  <= strap[3];
		ext_set    <= strap[2];
		core_store <= ~strap[3];
		ale_set  <= strap[1];
		ale_flt  <= strap[0];
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		`CHK(start_valid, 1'b1)
		`CHK(start_pc, pc)
		`CHK(flash_ctl, fc)
		`CHK(boot_en, en)
		@(posedge mclk_i);
		ext_set <= ~strap[2];
		ale_set <= ~strap[1];
		#1;
		`CHK(start_valid, 1'b0)
		`CHK(pin_oe, 1'b1)
		repeat (3) @(posedge mclk_i);
		#1;
		`CHK(start_pc, pc)
		`CHK(store_pin, ~strap[3])
		rd(BSC_OFS_STATUS, {4'h0, ~strap[2], en, 1'b1, fc == 8'h00});
	endtask

	task cr(input logic [7:0] fc, input logic fb, input logic ro, input logic [15:0] p,
		input bsc_tgt_t t, input logic [15:0] xa, input logic [15:0] m);
		wr(BSC_OFS_FLASH_CTL, fc);
		@(posedge mclk_i);
		code_rd_i        <= 1'b1;
		code_from_boot_i <= fb;
		code_rollover_i  <= ro;
		code_ptr_i       <= p;
		@(posedge mclk_i);
		code_rd_i <= 1'b0;
		#1;
		`CHK(code_valid, 1'b1)
		`CHK(code_tgt, t)
		`CHK(code_addr & m, xa & m)
		`CHK(hw_byte, (t == TG_HW_BYTE) ? 8'hC0 : 8'h00)
	endtask

	// Straps {store enable n, ext access n, latch enable, latch floating} and jump bit
	logic [3:0]  bs [7] = '{4'h6, 4'h5, 4'hE, 4'h2, 4'h4, 4'hE, 4'h6};
	logic        bj [7] = '{1, 1, 1, 1, 1, 0, 0};
	logic [15:0] bp [7] = '{16'hF800, 16'hF800, 16'h0000, 16'h0000, 16'h0000, 16'hF800,
		16'hF800};
	logic [7:0]  bf [7] = '{8'h00, 8'h00, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'h00};
	// Code reads: flash control, from boot, rollover, pointer, target, address, address mask
	logic [7:0]  cf [10] = '{8'h02, 8'h02, 8'h04, 8'h00, 8'h06, 8'h06, 8'h00, 8'h08, 8'h00,
		8'h02};
	logic [1:0]  cx [10] = '{0, 2, 0, 0, 0, 0, 2, 2, 1, 1};
	logic [15:0] cp [10] = '{16'h0085, 16'h00FF, 16'hABCD, 16'h1234, 16'h7FFF, 16'h8000,
		16'hF900, 16'h9234, 16'h1234, 16'h0010};
	bsc_tgt_t    ct [10] = '{TG_EXTRA_ROW, TG_EXTRA_ROW, TG_HW_BYTE, TG_USER, TG_USER, TG_NONE,
		TG_BOOT, TG_USER, TG_EXT_CODE, TG_NONE};
	logic [15:0] ca [10] = '{16'h0005, 16'h007F, 0, 16'h1234, 16'h7FFF, 0, 0, 16'h1234, 0, 0};
	logic [15:0] cm [10] = '{16'hFFFF, 16'hFFFF, 0, 16'hFFFF, 16'hFFFF, 0, 0, 16'hFFFF, 0, 0};

	initial begin
		{rst_i, por_i} = 2'b11;
		{store_set, ext_set, ale_set, ale_flt, core_store} = 5'h1D;
		{code_rd_i, code_from_boot_i, code_rollover_i, reg_wr_i, reg_rd_i} = 5'h00;
		code_ptr_i = 16'h0000;
		reg_addr_i = 4'h0;
		reg_wdata_i = 8'h00;
		boot(4'hE, 16'hF800, 8'hF0, 1'b0);
		rd(BSC_OFS_SECURITY, 8'h80);
		rd(BSC_OFS_BOOT_VEC, 8'hFC);
		rd(BSC_OFS_LOADER_HI, 8'hFC);
		`CHK(loader_addr, 16'hFC00)
		wr(BSC_OFS_BOOT_VEC, 8'h12);
		rd(BSC_OFS_LOADER_HI, 8'h12);
		`CHK(loader_addr, 16'h1200)
		rd(4'hF, 8'h00);
		rd(BSC_OFS_AUX_CTL, 8'h00);
		rd(BSC_OFS_SPARE, 8'hFF);
		wr(BSC_OFS_SPARE, 8'h5A);
		rd(BSC_OFS_SPARE, 8'h5A);
		rd(BSC_OFS_BOOT_STAT, 8'hFF);
		$display("test defaults done");
		for (int i = 0; i < 7; i++) begin
			wr(BSC_OFS_SECURITY, bj[i] ? 8'hC0 : 8'h80);
			boot(bs[i], bp[i], bf[i], bj[i]);
		end
		$display("test boot choice done");
		wr(BSC_OFS_SECURITY, 8'hC0);
		boot(4'hE, 16'h0000, 8'hF0, 1'b1);
		for (int i = 0; i < 10; i++) begin
			cr(cf[i], cx[i][1], cx[i][0], cp[i], ct[i], ca[i], cm[i]);
		end
		wr(BSC_OFS_AUX_CTL, 8'h00);
		cr(8'h00, 1'b1, 1'b0, 16'hF900, TG_NONE, 0, 0);
		$display("test code reads done");
		wr(BSC_OFS_FLASH_CTL, 8'h0F);
		rd(BSC_OFS_FLASH_CTL, 8'h0E);
		wr(BSC_OFS_STATUS, 8'hFF);
		rd(BSC_OFS_STATUS, 8'h06);
		wr(BSC_OFS_PC_LO, 8'h55);
		rd(BSC_OFS_PC_LO, 8'h00);
		rd(BSC_OFS_PC_HI, 8'h00);
		$display("test registers done");
		close_out();
	end
endmodule
